// ===== int_test_defines.vh
// Purpose: shared constants of the interrupt test and priority promotion registers
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: printed offsets are register indices, byte address is four times the index
//
// Functional notes
// - the override enable bit is written only in a special mode with both interrupt masks set, and read anytime.
// - with override off, test bank writes are blocked and reads show the live request inputs.
// - with override on, the decoder is fed only from the test bank values, never from the live inputs.
// - requests pending when override is switched on stay pending until software overwrites them.
// - the four-bit bank select is read and written anytime and picks the bank of that vector nibble.
// - test bank reads work only in special modes, showing live or written values, and read zero otherwise.
// - test bank writes need a special mode, override on and the standard mask set, otherwise they are ignored.
// - each of the eight test bits forces one vector, bit 7 the nibble's 0xE vector down to bit 0 for 0x0.
// - one test bank exists per eight vectors, all at one address, chosen by the bank select.
// - with bank select 0xF only bits 2:0 are usable and bits 7:3 always read zero.
// - selecting a bank that does not exist makes writes do nothing and reads return zero.
// - the promotion register is readable anytime and written only while the standard mask is set.
// - software promotes an interrupt by writing its vector low byte, and it then outranks other standard ones.
// - an unimplemented vector or a value above 0xF2 promotes the external level interrupt at 0xFFF2.
// - an active promoted interrupt is handed to the decoder ahead of the other standard interrupts.
`ifndef INT_TEST_DEFINES_VH
`define INT_TEST_DEFINES_VH

`define TEST_CTRL_IDX 8'h15
`define TEST_BANK_IDX 8'h16
`define PROM_SEL_IDX 8'h1f
`define TEST_CTRL_ADDR 8'h54
`define TEST_BANK_ADDR 8'h58
`define PROM_SEL_ADDR 8'h7c

`define OVR_BIT 4
`define BANK_MSB 3
`define BANK_LSB 0
`define PROM_MSB 7
`define PROM_LSB 1

`define TEST_CTRL_RESET 8'h00
`define OVR_RESET 1'b0
`define BANK_SEL_RESET 4'h0
`define PROM_SEL_RESET 7'h79
`define TOP_BANK 4'hf
`define TOP_BANK_MASK 8'h07
`define FULL_BANK_MASK 8'hff
`define LEVEL_IRQ_IDX 7'h79
`define XIRQ_IDX 7'h7a

`endif

// ===== int_test_bank_mem.v
// Purpose: storage of the banked test bits, eight per bank
// Assumes: one bank written per cycle; snapshot and write never coincide
// Notes: read data comes out of a register, one cycle behind the select
`timescale 1ns/1ns
`default_nettype none
module int_test_bank_mem #(
    parameter NUM_BANKS = 16
) (
    input wire clock,
    input wire rst,
    input wire loadAll,
    input wire [NUM_BANKS*8-1:0] loadData,
    input wire wrEn,
    input wire [3:0] wrBank,
    input wire [7:0] wrData,
    input wire [3:0] rdBank,
    output reg [7:0] rdData_q,
    output wire [NUM_BANKS*8-1:0] bits
);
    reg [7:0] bank_q [0:NUM_BANKS-1];
    genvar g;

    generate
        for (g = 0; g < NUM_BANKS; g = g + 1) begin : banks
            always @(posedge clock) begin
                if (rst) begin
                    bank_q[g] <= 8'h00;
                end else if (loadAll) begin
                    bank_q[g] <= loadData[g*8 +: 8];
                end else if (wrEn && (wrBank == g)) begin
                    bank_q[g] <= wrData;
                end
            end
            assign bits[g*8 +: 8] = bank_q[g];
        end
    endgenerate

    always @(posedge clock) begin
        if (rst) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= bank_q[rdBank];
        end
    end
endmodule // int_test_bank_mem
`default_nettype wire

// ===== int_prio_encoder.v
// Purpose: ranks pending requests and names the winning vector
// Assumes: higher vector address means higher priority
// Notes: outputs are registered, one cycle after the request vector
`timescale 1ns/1ns
`default_nettype none
`include "int_test_defines.vh"
module int_prio_encoder #(
    parameter NUM_VEC = 128
) (
    input wire clock,
    input wire rst,
    input wire [NUM_VEC-1:0] req,
    input wire [6:0] promIdx,
    output reg vecValid_q,
    output reg [7:0] vecLow_q,
    output reg promActive_q
);
    reg found;
    reg [6:0] idx;
    integer i;

    always @* begin
        found = 1'b0;
        idx = 7'h00;
        // ascending scan, so the last hit is the highest address
        for (i = 0; i <= `LEVEL_IRQ_IDX; i = i + 1) begin
            if (req[i]) begin
                found = 1'b1;
                idx = i[6:0];
            end
        end
        if (req[promIdx]) begin
            found = 1'b1;
            idx = promIdx;
        end
        if (req[`XIRQ_IDX]) begin
            found = 1'b1;
            idx = `XIRQ_IDX;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            vecValid_q <= 1'b0;
            vecLow_q <= 8'h00;
            promActive_q <= 1'b0;
        end else begin
            vecValid_q <= found;
            vecLow_q <= {idx, 1'b0};
            promActive_q <= req[promIdx] && !req[`XIRQ_IDX];
        end
    end
endmodule // int_prio_encoder
`default_nettype wire

// ===== int_test_prio.v
// Purpose: interrupt test override, banked test registers and priority promotion
// Assumes: core supplies operating mode and both interrupt masks as levels
// Notes: APB slave with one wait state; decoder input is registered
`timescale 1ns/1ns
`default_nettype none
`include "int_test_defines.vh"
module int_test_prio #(
    parameter NUM_BANKS = 16,
    parameter [15:0] IMPL_BANKS = 16'hffff
) (
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire specialMode,
    input wire iMask,
    input wire xMask,
    input wire [NUM_BANKS*8-1:0] intReq,
    output reg testOverrideEnable,
    output reg [NUM_BANKS*8-1:0] decoderReq,
    output wire vecValid,
    output wire [7:0] vecLow,
    output wire promActive
);
    localparam NUM_VEC = NUM_BANKS * 8;

    reg [3:0] bankSel_q;
    reg [6:0] promSel_q;

    wire [NUM_VEC-1:0] testBits;
    wire [7:0] testRd;

    wire hitCtrl;
    wire hitBank;
    wire hitProm;
    wire mapped;
    wire complete;
    wire wrEn;
    wire ctrlWrOk;
    wire bankWrOk;
    wire promWrOk;
    wire bankExists;
    wire [7:0] bankMask;
    wire loadAll;
    wire [7:0] liveSlice;
    wire [7:0] bankView;
    wire [6:0] promIdx;
    wire promTooHigh;
    wire promBankMissing;

    reg [7:0] rdByte;
    reg [NUM_VEC-1:0] decoderReqD;

    // address decode
    assign hitCtrl = (paddr == `TEST_CTRL_ADDR);
    assign hitBank = (paddr == `TEST_BANK_ADDR);
    assign hitProm = (paddr == `PROM_SEL_ADDR);
    assign mapped = hitCtrl || hitBank || hitProm;

    // a transfer completes on the edge where pready is seen high
    assign complete = psel && penable && pready;
    assign wrEn = complete && pwrite;

    // write qualifiers
    assign ctrlWrOk = specialMode && iMask && xMask;
    assign bankExists = IMPL_BANKS[bankSel_q];
    assign bankWrOk = specialMode && testOverrideEnable && iMask && bankExists;
    assign promWrOk = iMask;

    assign bankMask = (bankSel_q == `TOP_BANK) ? `TOP_BANK_MASK : `FULL_BANK_MASK;

    // switching override on freezes the live requests into the banks
    assign loadAll = wrEn && hitCtrl && ctrlWrOk && pwdata[`OVR_BIT] && !testOverrideEnable;

    assign liveSlice = intReq[bankSel_q*8 +: 8];

    // the bank register holds what was written, live view only when override off
    assign bankView = testOverrideEnable ? testRd : liveSlice;

    int_test_bank_mem #(
        .NUM_BANKS(NUM_BANKS)
    ) bankMem (
        .clock(clock),
        .rst(rst),
        .loadAll(loadAll),
        .loadData(intReq & topBankFilter(1'b0)),
        .wrEn(wrEn && hitBank && bankWrOk),
        .wrBank(bankSel_q),
        .wrData(pwdata[7:0] & bankMask),
        .rdBank(bankSel_q),
        .rdData_q(testRd),
        .bits(testBits)
    );

    // clears the top bank bits above the three testable vectors
    function [NUM_VEC-1:0] topBankFilter;
        input dummy;
        integer k;
        begin
            topBankFilter = {NUM_VEC{1'b1}};
            for (k = 3; k < 8; k = k + 1) begin
                topBankFilter[(NUM_BANKS-1)*8 + k] = dummy;
            end
        end
    endfunction

    // promotion target fallback
    assign promTooHigh = (promSel_q > `LEVEL_IRQ_IDX);
    assign promBankMissing = !IMPL_BANKS[promSel_q[6:3]];
    // top bank vectors above 0xf2 are already caught by the range test
    assign promIdx = (promTooHigh || promBankMissing) ? `LEVEL_IRQ_IDX : promSel_q;

    // read mux
    always @* begin
        rdByte = 8'h00;
        if (hitCtrl) begin
            rdByte = {3'b000, testOverrideEnable, bankSel_q};
        end else if (hitBank) begin
            if (specialMode && bankExists) begin
                rdByte = bankView & bankMask;
            end else begin
                rdByte = 8'h00;
            end
        end else if (hitProm) begin
            rdByte = {promSel_q, 1'b0};
        end
    end

    // decoder source selection
    always @* begin
        if (testOverrideEnable) begin
            decoderReqD = testBits;
        end else begin
            decoderReqD = intReq;
        end
    end

    // apb handshake: one wait cycle so the bank read register has settled
    always @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= !mapped;
                prdata <= {24'h000000, rdByte};
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // control register
    always @(posedge clock) begin
        if (rst) begin
            testOverrideEnable <= `OVR_RESET;
            bankSel_q <= `BANK_SEL_RESET;
        end else if (wrEn && hitCtrl) begin
            bankSel_q <= pwdata[`BANK_MSB:`BANK_LSB];
            if (ctrlWrOk) begin
                testOverrideEnable <= pwdata[`OVR_BIT];
            end
        end
    end

    // promotion register
    always @(posedge clock) begin
        if (rst) begin
            promSel_q <= `PROM_SEL_RESET;
        end else if (wrEn && hitProm && promWrOk) begin
            promSel_q <= pwdata[`PROM_MSB:`PROM_LSB];
        end
    end

    // registered request vector to the decoder
    always @(posedge clock) begin
        if (rst) begin
            decoderReq <= {NUM_VEC{1'b0}};
        end else begin
            decoderReq <= decoderReqD;
        end
    end

    int_prio_encoder #(
        .NUM_VEC(NUM_VEC)
    ) prioEnc (
        .clock(clock),
        .rst(rst),
        .req(decoderReq),
        .promIdx(promIdx),
        .vecValid_q(vecValid),
        .vecLow_q(vecLow),
        .promActive_q(promActive)
    );
endmodule // int_test_prio
`default_nettype wire

// ===== int_test_prio_chk_sva.sv
// Purpose: port checks of the interrupt test block
// Assumes: bench holds levels steady in a transfer
// Notes: bound to every block instance
`timescale 1ns/1ns
`default_nettype none
`include "int_test_defines.vh"
module int_test_prio_chk #(
    parameter NUM_BANKS = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic specialMode,
    input wire logic iMask,
    input wire logic xMask,
    input wire logic [NUM_BANKS*8-1:0] intReq,
    input wire logic testOverrideEnable,
    input wire logic [NUM_BANKS*8-1:0] decoderReq,
    input wire logic vecValid
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic acc = psel && penable && pready;
    wire logic ctrlWr = acc && pwrite && paddr == `TEST_CTRL_ADDR;
    wire logic mapped = paddr inside {`TEST_CTRL_ADDR, `TEST_BANK_ADDR, `PROM_SEL_ADDR};
    AST_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    AST_SLVERR: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong");
    AST_NORMAL_ZERO: assert property (acc && !pwrite && paddr == `TEST_BANK_ADDR && !specialMode |-> prdata == 32'h0)
        else $error("bank read not zero");
    AST_OVR_WR: assert property ($changed(testOverrideEnable) |-> $past(ctrlWr && specialMode && iMask && xMask))
        else $error("override changed unasked");
    AST_LIVE: assert property (!$past(rst) && !$past(testOverrideEnable) |-> decoderReq == $past(intReq))
        else $error("live path broken");
    AST_SNAP: assert property ($rose(testOverrideEnable) |=> decoderReq[111:0] == $past(intReq[111:0], 2))
        else $error("pending requests lost");
    // two edges back: bank write lands, then decoder copy
    AST_HOLD: assert property ($past(testOverrideEnable) && $past(testOverrideEnable, 2)
        && !$past(acc && pwrite, 2) |-> $stable(decoderReq)) else $error("live inputs leak");
    AST_VEC: assert property (!$past(rst) |-> vecValid == |$past(decoderReq[`XIRQ_IDX:0]))
        else $error("vecValid wrong");
    cover property (acc && pslverr);
    cover property ($rose(testOverrideEnable));
    cover property (vecValid);
endmodule // int_test_prio_chk
bind int_test_prio int_test_prio_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .specialMode, .iMask, .xMask, .intReq, .testOverrideEnable,
    .decoderReq, .vecValid);
`default_nettype wire

// ===== core_model.sv
// Purpose: core side levels: mode, masks, requests
// Assumes: levels change just after a rising edge
// Notes: one request bit per vector, active high
`timescale 1ns/1ns
`default_nettype none
module core_model #(
    parameter NB = 16
) (
    input wire logic clock,
    output logic specialMode,
    output logic iMask,
    output logic xMask,
    output logic [NB*8-1:0] intReq
);
    initial {specialMode, iMask, xMask, intReq} = '0;
    task automatic drive(input logic s, input logic i, input logic x, input logic [NB*8-1:0] r);
        @(posedge clock);
        specialMode <= s;
        iMask <= i;
        xMask <= x;
        intReq <= r;
    endtask
endmodule // core_model
`default_nettype wire

// ===== test_interrupt_test_and_priority_regs.sv
// Purpose: register sequences on the interrupt test block
// Assumes: bank 14 left out to reach missing-bank paths
// Notes: decoder read three edges after a write lands
`timescale 1ns/1ns
`default_nettype none
`include "int_test_defines.vh"
module test_interrupt_test_and_priority_regs;
    localparam logic [7:0] CT = `TEST_CTRL_ADDR;
    localparam logic [7:0] TB = `TEST_BANK_ADDR;
    localparam logic [7:0] PS = `PROM_SEL_ADDR;
    localparam logic [127:0] REQ = {8'hfa, 88'h0, 8'ha5, 24'h0};
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, slvErr, testOverrideEnable, vecValid, promActive, specialMode, iMask, xMask;
    logic [7:0] vecLow;
    logic [127:0] intReq, decoderReq;
    int err_total = 0;
    int compares = 0;
    always #20 clock = ~clock;
    core_model u_core (.clock, .specialMode, .iMask, .xMask, .intReq);
    int_test_prio #(.IMPL_BANKS(16'hbfff)) u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .specialMode, .iMask, .xMask, .intReq, .testOverrideEnable, .decoderReq,
        .vecValid, .vecLow, .promActive);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'h1;
        // pre-edge values: the sampled pready and prdata
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        xfer(1'h0, a, 8'h00);
        chk(nm, {24'h0, exp}, rd);
    endtask
    task automatic dec(input logic [7:0] exp, input logic p);
        repeat (3) @(posedge clock);
        chk("vector", {22'h0, 1'h1, p, exp}, {22'h0, vecValid, promActive, vecLow});
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        rdc("ctrl", CT, 8'h00);
        rdc("prom", PS, 8'hf2);
        u_core.drive(1'h0, 1'h1, 1'h1, REQ);
        wr(CT, 8'h13);
        rdc("bank", TB, 8'h00);
        rdc("ctrl", CT, 8'h03);
        u_core.drive(1'h1, 1'h1, 1'h0, REQ);
        rdc("bank", TB, 8'ha5);
        wr(TB, 8'h5a);
        rdc("bank", TB, 8'ha5);
        wr(CT, 8'h0f);
        rdc("bank", TB, 8'h02);
        u_core.drive(1'h1, 1'h1, 1'h1, REQ);
        wr(CT, 8'h13);
        u_core.drive(1'h1, 1'h0, 1'h1, '1);
        rdc("ctrl", CT, 8'h13);
        chk("override", 32'h1, {31'h0, testOverrideEnable});
        rdc("bank", TB, 8'ha5);
        chk("decoder", 32'ha5, {24'h0, decoderReq[31:24]});
        wr(TB, 8'h3d);
        rdc("bank", TB, 8'ha5);
        u_core.drive(1'h1, 1'h1, 1'h1, '1);
        wr(TB, 8'h3d);
        rdc("bank", TB, 8'h3d);
        dec(8'hf2, 1'h1);
        wr(PS, 8'h30);
        rdc("prom", PS, 8'h30);
        dec(8'h30, 1'h1);
        wr(PS, 8'he0);
        dec(8'hf2, 1'h1);
        wr(PS, 8'h30);
        wr(PS, 8'hf4);
        dec(8'hf2, 1'h1);
        u_core.drive(1'h1, 1'h0, 1'h1, '1);
        wr(PS, 8'h30);
        dec(8'hf2, 1'h1);
        u_core.drive(1'h1, 1'h1, 1'h1, '1);
        wr(CT, 8'h1f);
        wr(TB, 8'hff);
        rdc("bank", TB, 8'h07);
        dec(8'hf4, 1'h0);
        wr(CT, 8'h1e);
        wr(TB, 8'hff);
        rdc("bank", TB, 8'h00);
        xfer(1'h0, 8'h60, 8'h00);
        chk("slverr", 32'h1, {31'h0, slvErr});
        wrap_up();
    end
endmodule // test_interrupt_test_and_priority_regs
`default_nettype wire
